/* rtl/clk_sync_pkg.sv */
/*
  Constants, types and helper functions for the switching-clock synchronisation block.
  Assumes a 40 MHz internal oscillator clock and a link clock near 12.5 MHz.
*/
package clk_sync_pkg;

  localparam int SYS_MHZ        = 40;
  localparam int SYS_HZ         = SYS_MHZ * 1_000_000;
  localparam int LINK_PERIOD_NS = 80;

  localparam int NOM_HZ_0       = 250_000;
  localparam int NOM_HZ_1       = 500_000;
  localparam int NOM_HZ_2       = 1_000_000;
  localparam int NOM_HZ_3       = 2_000_000;
  localparam int SLAVE_HZ       = 250_000;
  localparam int KEEP_HZ        = 275_000;

  localparam int FAST_NUM       = 10;
  localparam int FAST_DEN       = 11;

  localparam int DRIVE_NS       = 200;
  localparam int BLANK_NS       = 250;
  localparam int START_NS       = 1000;
  localparam int MIN_PULSE_NS   = 100;

  localparam logic [7:0] SLAVE_PER     = 8'(SYS_HZ / SLAVE_HZ);
  localparam logic [7:0] KEEP_PER      = 8'(SYS_HZ / KEEP_HZ);
  localparam logic [3:0] DRIVE_CYC     = 4'((DRIVE_NS * SYS_MHZ + 999) / 1000);
  localparam logic [3:0] BLANK_CYC     = 4'((BLANK_NS * SYS_MHZ + 999) / 1000);
  localparam logic [5:0] START_CYC     = 6'((START_NS * SYS_MHZ + 999) / 1000);
  localparam logic [1:0] MIN_PULSE_CYC = 2'((MIN_PULSE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [3:0] FAST_COUNT    = 4'ha;
  localparam logic [7:0] INTV_MAX      = 8'hff;

  typedef enum logic [1:0] {
    MODE_START  = 2'b00,
    MODE_MASTER = 2'b01,
    MODE_SLAVE  = 2'b10
  } mode_type;

  typedef struct packed {
    logic       slave_mode;
    logic       latched_slave;
    logic [1:0] slope_setting;
  } status_type;

  typedef struct packed {
    logic       s1;
    logic       s2;
    logic [1:0] high_cnt;
    logic       armed;
    logic       tgl;
  } link_state_type;

  typedef struct packed {
    mode_type   mode;
    logic       tsync1;
    logic       tsync2;
    logic       tprev;
    logic       lsync1;
    logic       lsync2;
    logic [1:0] strap1;
    logic [1:0] strap2;
    logic [5:0] start;
    logic [7:0] osc;
    logic [7:0] intv;
    logic [3:0] fast;
    logic [3:0] drive;
    logic [3:0] blank;
    logic       own;
    logic       latched;
    logic [1:0] slope;
    logic       sw_pulse;
    logic       pin;
  } state_type;

  function automatic logic [7:0] nominal_per(input logic [1:0] strap);
    logic [7:0] per;
    per = 8'(SYS_HZ / NOM_HZ_0);
    unique case (strap)
      2'h0: per = 8'(SYS_HZ / NOM_HZ_0);
      2'h1: per = 8'(SYS_HZ / NOM_HZ_1);
      2'h2: per = 8'(SYS_HZ / NOM_HZ_2);
      2'h3: per = 8'(SYS_HZ / NOM_HZ_3);
    endcase
    return per;
  endfunction : nominal_per

  function automatic logic [7:0] fast_thr(input logic [7:0] per);
    logic [15:0] prod;
    prod = 16'(per) * 16'(FAST_NUM);
    return 8'(prod / 16'(FAST_DEN));
  endfunction : fast_thr

endpackage : clk_sync_pkg

/* rtl/link_edge.sv */
/*
  Link-clock side of the sync line: synchronises the pin and turns each qualified high pulse into a toggle.
  Assumes the link clock is free running and much faster than the widest accepted pulse rate.
*/
`timescale 1ns/10ps
`default_nettype none
module link_edge (
  input  wire logic link_clk,
  input  wire logic resetn,
  input  wire logic sync_line_in,
  output var  logic pulse_tgl
);
  import clk_sync_pkg::*;

  link_state_type st_ff;
  link_state_type nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = sync_line_in;
    nxt_st.s2 = st_ff.s1;
    if (!st_ff.s2) begin
      nxt_st.high_cnt = 2'h0;
      nxt_st.armed    = 1'b1;
    end else if (st_ff.armed) begin
      // A pulse shorter than the minimum width never toggles, so glitches are not counted.
      if (st_ff.high_cnt == MIN_PULSE_CYC - 2'h1) begin
        nxt_st.tgl   = ~st_ff.tgl;
        nxt_st.armed = 1'b0;
      end else begin
        nxt_st.high_cnt = st_ff.high_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pulse_tgl = st_ff.tgl;

endmodule : link_edge
`default_nettype wire

/* rtl/switching_clock_sync.sv */
/*
  Master/slave switching-clock synchronisation over a shared sync line, clocked by the internal oscillator.
  Assumes resetn is the undervoltage lockout, the sync line is pulled low when nobody drives it, and
  the strap pins are static during power-up.
*/
//
// Behaviour
// - Default role is master, pulsing the sync line at the strapped frequency.
// - Slaves switch 180 degrees from the master, all sharing that offset.
// - A slave starts a new switching cycle on each received sync pulse that beats 275 kHz.
// - In slave mode the oscillator runs at 250 kHz and drives the line only when it expires without a sync pulse.
// - Become slave only after ten consecutive pulses faster than the oscillator top limit.
// - Stay slave while pulses beat 275 kHz; else drive one own pulse, then master.
// - Line low at power-up latches slave mode at 250 kHz until next lockout.
// - Accept sync pulses from 275 kHz to 2 MHz, at least 100 ns wide.
// - Devices following an external reference all align to it with zero offset.
// - Slope-compensation setting is captured at power-up and never changes.
// - The frequency strap is sampled once before switching and never driven.
`timescale 1ns/10ps
`default_nettype none
module switching_clock_sync (
  input  wire logic                     sys_clk,
  input  wire logic                     resetn,
  input  wire logic                     link_clk,
  input  wire logic                     sync_line_in,
  output var  logic                     sync_line_out,
  output var  logic                     sync_line_oe,
  input  wire logic [1:0]               freq_select_strap,
  output var  logic                     sw_pulse,
  output var  clk_sync_pkg::status_type status
);
  import clk_sync_pkg::*;

  state_type  st_ff;
  state_type  nxt_st;
  logic       pulse_tgl;
  logic       edge_ok;
  logic [7:0] per;

  link_edge u_link_edge (
    .link_clk     (link_clk),
    .resetn       (resetn),
    .sync_line_in (sync_line_in),
    .pulse_tgl    (pulse_tgl)
  );

  // Our own pulse echoes back through the link synchroniser, so edges are blanked while and just after we drive.
  assign edge_ok = (st_ff.tsync2 != st_ff.tprev) && (st_ff.drive == 4'h0) && (st_ff.blank == 4'h0);
  assign per     = (st_ff.mode == MODE_SLAVE) ? SLAVE_PER : nominal_per(st_ff.slope);

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.sw_pulse = 1'b0;
    nxt_st.tsync1   = pulse_tgl;
    nxt_st.tsync2   = st_ff.tsync1;
    nxt_st.tprev    = st_ff.tsync2;
    nxt_st.lsync1   = sync_line_in;
    nxt_st.lsync2   = st_ff.lsync1;
    nxt_st.strap1   = freq_select_strap;
    nxt_st.strap2   = st_ff.strap1;
    nxt_st.intv     = edge_ok ? 8'h00 : ((st_ff.intv == INTV_MAX) ? st_ff.intv : st_ff.intv + 8'h01);
    if (st_ff.drive != 4'h0) begin
      nxt_st.drive = st_ff.drive - 4'h1;
      if (st_ff.drive == 4'h1) begin
        nxt_st.blank = BLANK_CYC;
      end
    end else if (st_ff.blank != 4'h0) begin
      nxt_st.blank = st_ff.blank - 4'h1;
    end
    unique case (st_ff.mode)
      MODE_START: begin
        nxt_st.start = st_ff.start + 6'h01;
        if (st_ff.start == START_CYC - 6'h01) begin
          nxt_st.slope   = st_ff.strap2;
          nxt_st.latched = ~st_ff.lsync2;
          nxt_st.mode    = st_ff.lsync2 ? MODE_MASTER : MODE_SLAVE;
          nxt_st.osc     = 8'h00;
        end
      end
      MODE_MASTER: begin
        if (st_ff.osc == per - 8'h01) begin
          nxt_st.osc      = 8'h00;
          nxt_st.sw_pulse = 1'b1;
        end else begin
          nxt_st.osc = st_ff.osc + 8'h01;
        end
        // The sync pulse sits half a period after our own switching edge, so slaves land at 180 degrees.
        if (st_ff.osc == (per >> 1) && st_ff.drive == 4'h0) begin
          nxt_st.drive = DRIVE_CYC;
        end
        if (edge_ok) begin
          if (st_ff.intv < fast_thr(per)) begin
            if (st_ff.fast == FAST_COUNT - 4'h1) begin
              nxt_st.mode     = MODE_SLAVE;
              nxt_st.osc      = 8'h00;
              nxt_st.sw_pulse = 1'b1;
              nxt_st.fast     = 4'h0;
              nxt_st.own      = 1'b0;
            end else begin
              nxt_st.fast = st_ff.fast + 4'h1;
            end
          end else begin
            nxt_st.fast = 4'h0;
          end
        end else if (st_ff.intv >= fast_thr(per)) begin
          nxt_st.fast = 4'h0;
        end
      end
      MODE_SLAVE: begin
        // An edge from a reference clock restarts every follower alike, which gives zero offset among them.
        if (edge_ok && st_ff.intv < KEEP_PER) begin
          nxt_st.osc      = 8'h00;
          nxt_st.sw_pulse = 1'b1;
          nxt_st.own      = 1'b0;
        end else if (st_ff.osc == SLAVE_PER - 8'h01) begin
          nxt_st.osc      = 8'h00;
          nxt_st.sw_pulse = 1'b1;
          nxt_st.drive    = DRIVE_CYC;
          nxt_st.own      = ~st_ff.latched;
        end else begin
          nxt_st.osc = st_ff.osc + 8'h01;
        end
        if (st_ff.drive == 4'h1 && st_ff.own && !st_ff.latched) begin
          nxt_st.mode = MODE_MASTER;
          nxt_st.own  = 1'b0;
          nxt_st.fast = 4'h0;
        end
      end
      default: begin
        nxt_st.mode = MODE_START;
      end
    endcase
    nxt_st.pin = (nxt_st.drive != 4'h0);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // The strap pin is input only here; the device never drives it after sampling.
  assign sync_line_out        = st_ff.pin;
  assign sync_line_oe         = st_ff.pin;
  assign sw_pulse             = st_ff.sw_pulse;
  // One assignment drives the whole status word, so it has a single driver.
  assign status = '{
    slave_mode:    (st_ff.mode == MODE_SLAVE),
    latched_slave: st_ff.latched,
    slope_setting: st_ff.slope
  };

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  master_drive_a: assert property (
    (st_ff.mode == MODE_MASTER && st_ff.osc == (per >> 1) && st_ff.drive == 4'h0)
    |=> sync_line_oe && sync_line_out)
    else $error("master did not drive sync pulse");
  master_wrap_a: assert property (
    (st_ff.mode == MODE_MASTER && st_ff.osc == per - 8'h01)
    |=> sw_pulse)
    else $error("master missed its switching edge");
  phase_half_a: assert property (
    (st_ff.mode == MODE_MASTER && $rose(sync_line_oe))
    |-> $past(st_ff.osc) == (per >> 1))
    else $error("master sync pulse not at half period");
  slave_align_a: assert property (
    (st_ff.mode == MODE_SLAVE && edge_ok && st_ff.intv < KEEP_PER)
    |=> sw_pulse && st_ff.osc == 8'h00)
    else $error("slave not aligned to received pulse");
  slave_rate_a: assert property (
    (st_ff.mode == MODE_SLAVE && st_ff.osc == SLAVE_PER - 8'h01 && !edge_ok)
    |=> sw_pulse ##1 sync_line_oe)
    else $error("slave did not pulse at slave rate");
  // A slave that outran its own period would mean the 250 kHz fallback never fires.
  slave_osc_a: assert property (
    status.slave_mode
    |-> st_ff.osc < SLAVE_PER)
    else $error("slave oscillator beyond its period");
  enter_slave_a: assert property (
    (st_ff.mode == MODE_MASTER && edge_ok && st_ff.intv < fast_thr(per) && st_ff.fast == FAST_COUNT - 4'h1)
    |=> status.slave_mode)
    else $error("master did not become slave");
  return_master_a: assert property (
    (st_ff.mode == MODE_SLAVE && st_ff.drive == 4'h1 && st_ff.own && !st_ff.latched)
    |=> st_ff.mode == MODE_MASTER)
    else $error("slave did not return to master");
  latched_hold_a: assert property (
    status.latched_slave
    |=> status.latched_slave && status.slave_mode)
    else $error("latched slave mode lost");
  line_capture_a: assert property (
    (st_ff.mode == MODE_START && st_ff.start == START_CYC - 6'h01)
    |=> status.latched_slave == !$past(st_ff.lsync2))
    else $error("power-up line level not captured");
  pulse_width_a: assert property (
    $rose(sync_line_oe)
    |-> sync_line_oe [*8] ##1 !sync_line_oe)
    else $error("own sync pulse width wrong");
  slope_fixed_a: assert property (
    (st_ff.mode != MODE_START)
    |=> $stable(status.slope_setting))
    else $error("slope setting changed");
  // The strap is read once, so a late strap change must never reach the slope setting.
  strap_capture_a: assert property (
    (st_ff.mode == MODE_START && st_ff.start == START_CYC - 6'h01)
    |=> status.slope_setting == $past(st_ff.strap2))
    else $error("strap not captured at start end");
  start_quiet_a: assert property (
    (st_ff.mode == MODE_START)
    |-> !sync_line_oe && !sw_pulse)
    else $error("switching before start phase ended");
  fast_clear_a: assert property (
    (st_ff.mode == MODE_MASTER && !edge_ok && st_ff.intv >= fast_thr(per))
    |=> st_ff.fast == 4'h0)
    else $error("fast pulse count not cleared");
  fast_count_a: assert property (
    (st_ff.mode == MODE_MASTER && edge_ok && st_ff.intv < fast_thr(per) && st_ff.fast != FAST_COUNT - 4'h1)
    |=> st_ff.fast == $past(st_ff.fast) + 4'h1)
    else $error("fast pulse not counted");

endmodule : switching_clock_sync
`default_nettype wire

/* tb/sync_partner.sv */
/* Far-side model of the sync line: another regulator or an external clock.
   Assumes link_clk runs free; a released line reads low through its pull-down. */
`timescale 1ns/10ps
`default_nettype none
module sync_partner (
  input  wire logic       link_clk,
  input  wire logic [7:0] per,
  input  wire logic       hold_en,
  input  wire logic       hold_val,
  output var  logic       drv_oe,
  output var  logic       drv_val,
  output var  logic [7:0] pulses
);
  logic [7:0] cnt = 8'hff;
  initial pulses = 8'h00;
  // Pulse spacing is per link cycles; the bench sets 22, 50 or 44, and zero stops the pulses.
  always @(posedge link_clk) begin
    cnt <= (cnt == 8'hff) ? cnt : cnt + 8'h01;
    if (per != 8'h00 && cnt >= per - 8'h01) begin
      cnt    <= 8'h00;
      pulses <= pulses + 8'h01;
    end
  end
  // Three link cycles high, so every pulse is well over the width floor.
  assign drv_oe  = hold_en | (cnt < 8'h03);
  // Holding the line at power-up picks master or latched slave.
  assign drv_val = hold_en ? hold_val : 1'b1;
endmodule : sync_partner
`default_nettype wire

/* tb/test_switching_clock_sync.sv */
/* Self-checking bench for the sync block: master periods, slave entry and exit, latched slave.
   Assumes the sync_partner model and a pulled-low shared line. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module test_switching_clock_sync;
  import clk_sync_pkg::*;
  typedef struct packed {logic [7:0] per; logic [7:0] tol; logic slave;} note_type;
  logic       sys_clk  = 1'b0;
  logic       link_clk = 1'b0;
  logic       resetn   = 1'b0;
  logic [1:0] strap    = 2'h0;
  logic [7:0] per      = 8'h00;
  logic       hold_en  = 1'b1;
  logic       hold_val = 1'b1;
  logic       out, oe, sw, p_oe, p_val, line;
  logic [7:0] pulses;
  status_type status;
  note_type   notes[$];
  note_type   n;
  int         num_errors = 0, samples_checked = 0, cyc = 0, last = 0, gap = 0;

  initial forever #12.5 sys_clk = ~sys_clk;
  initial begin
    #7;
    forever #40 link_clk = ~link_clk;
  end
  // The partner wins over the DUT when both drive; nobody driving leaves the pull-down low.
  assign line = p_oe ? p_val : (oe & out);

  switching_clock_sync i_dut (.sys_clk(sys_clk), .resetn(resetn), .link_clk(link_clk),
    .sync_line_in(line), .sync_line_out(out), .sync_line_oe(oe),
    .freq_select_strap(strap), .sw_pulse(sw), .status(status));
  sync_partner i_far (.link_clk(link_clk), .per(per), .hold_en(hold_en),
    .hold_val(hold_val), .drv_oe(p_oe), .drv_val(p_val), .pulses(pulses));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      tally_and_finish();
    end
    if (sw === 1'b1) begin
      last <= cyc;
      if (notes.size() > 0) begin
        n = notes.pop_front();
        gap = cyc - last;
        `CHK("sw_period", 1'b1, (gap <= n.per + n.tol) && (gap + n.tol >= n.per))
        `CHK("slave_mode", n.slave, status.slave_mode)
      end
    end
  end

  task automatic note(input logic [7:0] p, input logic [7:0] t, input logic s);
    notes.push_back({p, t, s});
  endtask : note

  task automatic drain;
    for (int i = 0; i < 3000 && notes.size() > 0; i++) @(posedge sys_clk);
    `CHK("notes_left", 0, notes.size())
  endtask : drain

  task automatic power_up(input logic [1:0] s, input logic lvl);
    resetn   <= 1'b0;
    strap    <= s;
    hold_en  <= 1'b1;
    hold_val <= lvl;
    per      <= 8'h00;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (60) @(posedge sys_clk);
    hold_en <= 1'b0;
    strap   <= 2'($urandom);
    repeat (400) @(posedge sys_clk);
  endtask : power_up

  task automatic burst(input int cnt, input logic [7:0] p);
    logic [7:0] stop;
    stop = pulses + 8'(cnt);
    per <= p;
    for (int i = 0; i < 20000 && pulses != stop; i++) @(posedge sys_clk);
  endtask : burst

  initial begin
    void'($urandom(32'hb93bb334));
    for (int s = 0; s < 4; s++) begin
      power_up(2'(s), 1'b1);
      `CHK("latched", 1'b0, status.latched_slave)
      `CHK("slope", 2'(s), status.slope_setting)
      note(8'(160 >> s), 8'h00, 1'b0);
      note(8'(160 >> s), 8'h00, 1'b0);
      drain();
      $display("master strap %0d done", s);
    end
    // A 70-cycle spacing survives one blanked event, since twice it stays under the threshold.
    power_up(2'h0, 1'b1);
    burst(9, 8'h16);
    burst(1, 8'h32);
    burst(9, 8'h16);
    `CHK("early_slave", 1'b0, status.slave_mode)
    burst(6, 8'h16);
    `CHK("slave_entry", 1'b1, status.slave_mode)
    // Each burst ends as its last pulse starts, so that pulse's result is still in flight.
    note(8'h46, 8'h01, 1'b1);
    note(8'h46, 8'h01, 1'b1);
    burst(3, 8'h16);
    note(8'h46, 8'h01, 1'b1);
    note(8'h8d, 8'h01, 1'b1);
    note(8'h8d, 8'h01, 1'b1);
    burst(4, 8'h2c);
    per <= 8'h00;
    note(8'h8d, 8'h01, 1'b1);
    note(8'ha0, 8'h02, 1'b1);
    note(8'ha0, 8'hff, 1'b0);
    note(8'ha0, 8'h00, 1'b0);
    drain();
    $display("slave entry and exit done");
    power_up(2'h3, 1'b0);
    `CHK("latched_on", 1'b1, status.latched_slave)
    `CHK("slope_latched", 2'h3, status.slope_setting)
    note(8'ha0, 8'h00, 1'b1);
    note(8'ha0, 8'h00, 1'b1);
    drain();
    $display("latched slave done");
    tally_and_finish();
  end
endmodule : test_switching_clock_sync
`default_nettype wire
